// ===== design/tip_pwm.sv
// Purpose: three-phase centre-aligned pwm generator with dead time and chopping
// Assumes: settings are static or change only between periods; i_mclk 100 MHz
// Notes:   shutdown path bypasses every flop so it works without a clock
//
// Notes on behaviour
// - six outputs, three phase pairs of one high-side and one low-side drive.
// - period and dead time each come from their own setting input.
// - three duty settings, each setting the duty of one output pair.
// - each of the six outputs has its own enable bit.
// - per-pair crossover bit swaps high-side and low-side waveforms.
// - chopping mixes outputs with a carrier whose rate an 8-bit field sets.
// - chopping is enabled separately for high-side and low-side outputs.
// - single update mode loads duty once per period, symmetric about midpoint.
// - double update mode reloads duty again at the midpoint.
// - one control bit selects single or double update.
// - internal sync pulse each period start, plus midpoint in double mode.
// - internal sync also drives the sync pin, width from its own setting.
// - external sync pulse on the sync pin can replace the internal one.
// - optional synchroniser on external sync, adding latency and jitter.
// - shutdown input low forces all six outputs to the off level, high.
// - shutdown path is purely combinational, immune to clock loss.
// - status shows shutdown input level and which half of the period runs.
// - only active-high patterns; no output polarity inversion.
`timescale 1ns/1ns
`default_nettype none
module tip_pwm
    import tip_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic              i_run,
    input  wire logic [PER_W-1:0]  i_period_setting,
    input  wire logic [DT_W-1:0]   i_dead_time_setting,
    input  wire logic [SW_W-1:0]   i_sync_pulse_width_setting,
    input  wire logic [PER_W-1:0]  i_phase0_duty,
    input  wire logic [PER_W-1:0]  i_phase1_duty,
    input  wire logic [PER_W-1:0]  i_phase2_duty,
    input  wire logic [NOUT-1:0]   i_output_enable,
    input  wire logic [NPH-1:0]    i_crossover,
    input  wire logic [CHOP_W-1:0] i_chop_rate,
    input  wire logic              i_chop_high_en,
    input  wire logic              i_chop_low_en,
    input  wire logic              i_double_update,
    input  wire logic              i_ext_sync_sel,
    input  wire logic              i_ext_sync_resync,
    input  wire logic              i_sync_pin,
    output logic                   o_sync_pin,
    output logic                   o_sync_oe,
    input  wire logic              i_shutdown_input_n,
    output logic                   o_trip_level,
    output logic                   o_second_half,
    output logic                   o_phase0_high_out,
    output logic                   o_phase0_low_out,
    output logic                   o_phase1_high_out,
    output logic                   o_phase1_low_out,
    output logic                   o_phase2_high_out,
    output logic                   o_phase2_low_out
);
    // centre threshold: output is active while count is at or above it, unless duty is zero
    function automatic logic is_active(input logic [PER_W-1:0] cnt,
                                       input logic [PER_W-1:0] per,
                                       input logic [PER_W-1:0] duty);
        logic [PER_W-1:0] thr;
        thr = (duty >= per) ? CNT_RST : per - duty;
        return (duty != DUTY_RST) && (cnt >= thr);
    endfunction

    logic [PER_W-1:0]  cnt_ff;
    tip_dir_t          dir_ff;
    logic              running_ff;
    logic [PER_W-1:0]  per_sh_ff;
    logic [PER_W-1:0]  duty_sh_ff [NPH];
    logic [PER_W-1:0]  nxt_cnt;
    tip_dir_t          nxt_dir;
    logic [PER_W-1:0]  nxt_per_sh;
    logic [PER_W-1:0]  nxt_duty_sh [NPH];
    logic [PER_W-1:0]  duty_in [NPH];
    logic              start_evt;
    logic              mid_evt;
    logic              sync_evt;
    logic              ext_restart;
    logic              sync_direct_ff;
    logic              sync_prev_ff;
    logic              sync_resync;
    logic              sync_level;
    logic [SW_W-1:0]   sw_cnt_ff;
    logic              sync_out_ff;
    logic [SW_W-1:0]   nxt_sw_cnt;
    logic [CHOP_W-1:0] chop_cnt_ff;
    logic              chop_ff;
    logic [CHOP_W-1:0] nxt_chop_cnt;
    logic              nxt_chop;
    logic [NOUT-1:0]   want;
    logic [NOUT-1:0]   dead_out;
    logic [NOUT-1:0]   out_ff;
    logic [NOUT-1:0]   nxt_out;
    logic [NOUT-1:0]   trip_out;

    assign duty_in[0] = i_phase0_duty;
    assign duty_in[1] = i_phase1_duty;
    assign duty_in[2] = i_phase2_duty;

    tip_sync u_sync_in (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_async   (i_sync_pin),
        .i_rst_val (1'b0),
        .o_level   (sync_resync)
    );

    // bypass path trusts the pin to be synchronous: one flop, no filter
    assign sync_level  = i_ext_sync_resync ? sync_resync : sync_direct_ff;
    assign ext_restart = i_ext_sync_sel & sync_level & ~sync_prev_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            sync_direct_ff <= 1'b0;
            sync_prev_ff   <= 1'b0;
        end else begin
            sync_direct_ff <= i_sync_pin;
            sync_prev_ff   <= sync_level;
        end
    end
    assign start_evt = i_run & (~running_ff | ext_restart
                              | (dir_ff == TIP_DOWN && cnt_ff == CNT_RST));
    assign mid_evt   = i_run & ~start_evt & (dir_ff == TIP_UP) & (cnt_ff >= per_sh_ff);
    assign sync_evt  = start_evt | (mid_evt & i_double_update);

    always_comb begin
        nxt_cnt    = cnt_ff;
        nxt_dir    = dir_ff;
        nxt_per_sh = per_sh_ff;
        for (int i = 0; i < NPH; i++) begin
            nxt_duty_sh[i] = duty_sh_ff[i];
        end
        if (!i_run) begin
            nxt_cnt = CNT_RST;
            nxt_dir = TIP_UP;
        end else if (start_evt) begin
            nxt_cnt    = CNT_RST;
            nxt_dir    = TIP_UP;
            nxt_per_sh = i_period_setting;
            for (int i = 0; i < NPH; i++) begin
                nxt_duty_sh[i] = duty_in[i];
            end
        end else if (mid_evt) begin
            nxt_dir = TIP_DOWN;
            nxt_cnt = per_sh_ff;
            if (i_double_update) begin
                for (int i = 0; i < NPH; i++) begin
                    nxt_duty_sh[i] = duty_in[i];
                end
            end
        end else if (dir_ff == TIP_UP) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end else begin
            nxt_cnt = cnt_ff - 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cnt_ff     <= CNT_RST;
            dir_ff     <= TIP_UP;
            running_ff <= 1'b0;
            per_sh_ff  <= CNT_RST;
            for (int i = 0; i < NPH; i++) begin
                duty_sh_ff[i] <= DUTY_RST;
            end
        end else begin
            cnt_ff     <= nxt_cnt;
            dir_ff     <= nxt_dir;
            running_ff <= i_run;
            per_sh_ff  <= nxt_per_sh;
            for (int i = 0; i < NPH; i++) begin
                duty_sh_ff[i] <= nxt_duty_sh[i];
            end
        end
    end
    always_comb begin
        nxt_sw_cnt = sw_cnt_ff;
        if (sync_evt) begin
            nxt_sw_cnt = i_sync_pulse_width_setting;
        end else if (sw_cnt_ff != SW_RST) begin
            nxt_sw_cnt = sw_cnt_ff - 10'h001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            sw_cnt_ff   <= SW_RST;
            sync_out_ff <= 1'b0;
        end else begin
            sw_cnt_ff   <= nxt_sw_cnt;
            sync_out_ff <= (nxt_sw_cnt != SW_RST);
        end
    end

    assign o_sync_pin = sync_out_ff;
    assign o_sync_oe  = ~i_ext_sync_sel;
    always_comb begin
        nxt_chop_cnt = chop_cnt_ff + 8'h01;
        nxt_chop     = chop_ff;
        if (chop_cnt_ff >= i_chop_rate) begin
            nxt_chop_cnt = CHOP_RST;
            nxt_chop     = ~chop_ff;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            chop_cnt_ff <= CHOP_RST;
            chop_ff     <= 1'b0;
        end else begin
            chop_cnt_ff <= nxt_chop_cnt;
            chop_ff     <= nxt_chop;
        end
    end
    // even bit is high side, odd bit low side of the same phase
    genvar g;
    generate
        for (g = 0; g < NPH; g++) begin : g_phase
            assign want[2*g]   = i_run & is_active(cnt_ff, per_sh_ff, duty_sh_ff[g]);
            assign want[2*g+1] = i_run & ~is_active(cnt_ff, per_sh_ff, duty_sh_ff[g]);
        end
        for (g = 0; g < NOUT; g++) begin : g_dead
            tip_dead u_dead (
                .i_mclk   (i_mclk),
                .i_resetn (i_resetn),
                .i_want   (want[g]),
                .i_dead   (i_dead_time_setting),
                .o_drive  (dead_out[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_out = ALL_OFF;
        for (int i = 0; i < NPH; i++) begin
            if (i_crossover[i]) begin
                nxt_out[2*i]   = dead_out[2*i+1];
                nxt_out[2*i+1] = dead_out[2*i];
            end else begin
                nxt_out[2*i]   = dead_out[2*i];
                nxt_out[2*i+1] = dead_out[2*i+1];
            end
            nxt_out[2*i]   = nxt_out[2*i] & (~i_chop_high_en | chop_ff);
            nxt_out[2*i+1] = nxt_out[2*i+1] & (~i_chop_low_en | chop_ff);
        end
        nxt_out = nxt_out & i_output_enable;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            out_ff <= OUT_RST;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // no flop between the shutdown pin and the outputs
    assign trip_out = i_shutdown_input_n ? out_ff : OUT_OFF;

    assign o_phase0_high_out = trip_out[0];
    assign o_phase0_low_out  = trip_out[1];
    assign o_phase1_high_out = trip_out[2];
    assign o_phase1_low_out  = trip_out[3];
    assign o_phase2_high_out = trip_out[4];
    assign o_phase2_low_out  = trip_out[5];
    tip_sync u_trip_in (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_async   (i_shutdown_input_n),
        .i_rst_val (1'b1),
        .o_level   (o_trip_level)
    );
    assign o_second_half = (dir_ff == TIP_DOWN);
    sequence s_mid;
        mid_evt;
    endsequence
    sequence s_descend;
        (dir_ff == TIP_DOWN) && (cnt_ff == $past(per_sh_ff));
    endsequence
    property p_pair_excl;
        @(posedge i_mclk) disable iff (!i_resetn)
            !(dead_out[0] && dead_out[1]) && !(dead_out[2] && dead_out[3])
            && !(dead_out[4] && dead_out[5]);
    endproperty
    a_pair_excl: assert property (p_pair_excl) else $error("pair active together");
    property p_trip;
        @(posedge i_mclk) !i_shutdown_input_n |-> trip_out == OUT_OFF;
    endproperty
    a_trip: assert property (p_trip) else $error("outputs not off under shutdown");
    property p_reverse;
        @(posedge i_mclk) disable iff (!i_resetn) s_mid |=> s_descend;
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal at top");
    property p_single_hold;
        @(posedge i_mclk) disable iff (!i_resetn)
            mid_evt && !i_double_update |=> $stable(duty_sh_ff[0]);
    endproperty
    a_single_hold: assert property (p_single_hold) else $error("midpoint reload");
    property p_double_load;
        @(posedge i_mclk) disable iff (!i_resetn)
            mid_evt && i_double_update |=> duty_sh_ff[0] == $past(i_phase0_duty);
    endproperty
    a_double_load: assert property (p_double_load) else $error("no midpoint load");
    property p_sync_pulse;
        @(posedge i_mclk) disable iff (!i_resetn)
            sync_evt && i_sync_pulse_width_setting > 10'h001 |=> sync_out_ff [*2];
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too short");
    property p_mid_sync;
        @(posedge i_mclk) disable iff (!i_resetn)
            mid_evt && i_double_update && i_sync_pulse_width_setting != SW_RST |=> sync_out_ff;
    endproperty
    a_mid_sync: assert property (p_mid_sync) else $error("midpoint sync missing");
    property p_enable;
        @(posedge i_mclk) disable iff (!i_resetn)
            !i_output_enable[0] |=> !out_ff[0];
    endproperty
    a_enable: assert property (p_enable) else $error("disabled output active");
    property p_cross;
        @(posedge i_mclk) disable iff (!i_resetn)
            i_crossover[0] && !i_chop_high_en && i_output_enable[0]
            |=> out_ff[0] == $past(dead_out[1]);
    endproperty
    a_cross: assert property (p_cross) else $error("crossover not applied");
    property p_ext_restart;
        @(posedge i_mclk) disable iff (!i_resetn)
            ext_restart && i_run |=> cnt_ff == CNT_RST && dir_ff == TIP_UP;
    endproperty
    a_ext_restart: assert property (p_ext_restart) else $error("ext sync ignored");
endmodule
`default_nettype wire

// ===== pkg/tip_pkg.sv
// Purpose: shared widths, reset values and timing figures of the three-phase pwm
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   settings arrive as plain ports; no register bus
package tip_pkg;
    localparam int          PER_W       = 16;
    localparam int          DT_W        = 10;
    localparam int          SW_W        = 10;
    localparam int          CHOP_W      = 8;
    localparam int          NPH         = 3;
    localparam int          NOUT        = 2 * NPH;
    localparam int          CLK_NS      = 10;
    // least external sync pulse width, two core clocks
    localparam int          SYNC_MIN_NS = 2 * CLK_NS;
    localparam int          SYNC_MIN_CYC = (SYNC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [PER_W-1:0]  CNT_RST   = 16'h0000;
    localparam logic [PER_W-1:0]  DUTY_RST  = 16'h0000;
    localparam logic [SW_W-1:0]   SW_RST    = 10'h000;
    localparam logic [DT_W-1:0]   DT_RST    = 10'h000;
    localparam logic [CHOP_W-1:0] CHOP_RST  = 8'h00;
    localparam logic [NOUT-1:0]   OUT_RST   = 6'h00;
    // level that every output takes while shutdown is asserted
    localparam logic [NOUT-1:0]   OUT_OFF   = 6'h3f;
    localparam logic [NOUT-1:0]   ALL_OFF   = 6'h00;
    typedef enum logic {TIP_UP, TIP_DOWN} tip_dir_t;
endpackage

// ===== design/tip_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: input asynchronous to i_mclk
// Notes:   output changes once the second and third flop agree
`timescale 1ns/1ns
`default_nettype none
module tip_sync
    import tip_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_resetn,
    input  wire logic i_async,
    input  wire logic i_rst_val,
    output logic      o_level
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;
    logic nxt_q;

    always_comb begin
        nxt_q = q_ff;
        if (s2_ff == s3_ff) begin
            nxt_q = s3_ff;
        end
    end

    // reset value is a tie-off constant at the instance
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s1_ff <= i_rst_val;
            s2_ff <= i_rst_val;
            s3_ff <= i_rst_val;
            q_ff  <= i_rst_val;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign o_level = q_ff;
endmodule
`default_nettype wire

// ===== design/tip_dead.sv
// Purpose: dead-time inserter for one output; delays each turn-on
// Assumes: i_want of the partner output is the complement of this one
// Notes:   turn-off is immediate, turn-on waits dead time plus one clock
`timescale 1ns/1ns
`default_nettype none
module tip_dead
    import tip_pkg::*;
(
    input  wire logic            i_mclk,
    input  wire logic            i_resetn,
    input  wire logic            i_want,
    input  wire logic [DT_W-1:0] i_dead,
    output logic                 o_drive
);
    logic [DT_W-1:0] cnt_ff;
    logic            drive_ff;
    logic [DT_W-1:0] nxt_cnt;
    logic            nxt_drive;

    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_drive = drive_ff;
        if (!i_want) begin
            nxt_drive = 1'b0;
            nxt_cnt   = DT_RST;
        end else if (!drive_ff) begin
            if (cnt_ff >= i_dead) begin
                nxt_drive = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 10'h001;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            cnt_ff   <= DT_RST;
            drive_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            drive_ff <= nxt_drive;
        end
    end

    assign o_drive = drive_ff;

    property p_off_fast;
        @(posedge i_mclk) disable iff (!i_resetn) !i_want |=> !drive_ff;
    endproperty
    a_off_fast: assert property (p_off_fast) else $error("drive outlived its request");

    property p_on_late;
        @(posedge i_mclk) disable iff (!i_resetn)
            $rose(drive_ff) |-> $past(cnt_ff) >= $past(i_dead);
    endproperty
    a_on_late: assert property (p_on_late) else $error("turn-on before dead time");
endmodule
`default_nettype wire

// ===== tb/tip_gate_model.sv
// Purpose: gate-driver model on the six phase drives, counts shoot-through
// Assumes: all-high while shutdown is asserted is the off state, not a conflict
// Notes:   samples on the falling edge, away from the drive updates
`timescale 1ns/1ns
`default_nettype none
module tip_gate_model
    import tip_pkg::*;
(
    input  wire logic            i_mclk,
    input  wire logic            i_shutdown_input_n,
    input  wire logic [NOUT-1:0] i_drive,
    output logic [15:0]          o_clash
);
    logic        hit;
    logic [15:0] clash_cnt = 16'h0000;
    assign o_clash = clash_cnt;
    always @(negedge i_mclk) begin
        hit = 1'b0;
        // drive 2k is the high side and 2k+1 the low side of phase k
        for (int k = 0; k < NPH; k++) begin
            // a tripped bridge is off whatever the pair shows
            if (i_shutdown_input_n && i_drive[2*k] && i_drive[2*k+1]) begin
                hit = 1'b1;
            end
        end
        if (hit) begin
            clash_cnt <= clash_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== tb/three_phase_inverter_pwm_test.sv
// Purpose: self-checking bench for the three-phase pwm generator
// Assumes: windows are measured between rising edges of the internal sync pulse
// Notes:   figures are compared as differences so fixed pipeline lag cancels out
`timescale 1ns/1ns
`default_nettype none
module three_phase_inverter_pwm_test;
    import tip_pkg::*;
    logic               i_mclk   = 1'b0;
    logic               resetn   = 1'b0;
    logic               run      = 1'b0;
    logic [PER_W-1:0]   per      = 16'h0008;
    logic [DT_W-1:0]    dt       = 10'h002;
    logic [SW_W-1:0]    sw       = 10'h003;
    logic [PER_W-1:0]   d0       = 16'h0004;
    logic [NOUT-1:0]    oe       = 6'h3f;
    logic [NPH-1:0]     xo       = 3'h0;
    logic               chh      = 1'b0;
    logic               chl      = 1'b0;
    logic               dbl      = 1'b0;
    logic               ext      = 1'b0;
    logic               rsy      = 1'b0;
    logic               spin     = 1'b0;
    logic               trip_n   = 1'b1;
    logic               last_s   = 1'b0;
    logic               last0    = 1'b0;
    wire logic          sync_o;
    wire logic          sync_oe;
    wire logic          trip_lvl;
    wire logic          half;
    wire logic          pin_w;
    wire logic [15:0]   clash;
    wire logic [NOUT-1:0] outs;
    int                 fails = 0;
    int                 n_compared = 0;
    int                 t_per, swc, rises, t0, t1, h0, l0;
    int                 hi [NOUT];

    always #5 i_mclk = ~i_mclk;
    // the pin carries the device pulse while it drives, else the bench level
    assign pin_w = sync_oe ? sync_o : spin;

    tip_pwm i_dut (
        .i_mclk(i_mclk), .i_resetn(resetn), .i_run(run),
        .i_period_setting(per), .i_dead_time_setting(dt),
        .i_sync_pulse_width_setting(sw), .i_phase0_duty(d0),
        .i_phase1_duty(16'h0002), .i_phase2_duty(16'h0006),
        .i_output_enable(oe), .i_crossover(xo), .i_chop_rate(8'h01),
        .i_chop_high_en(chh), .i_chop_low_en(chl), .i_double_update(dbl),
        .i_ext_sync_sel(ext), .i_ext_sync_resync(rsy), .i_sync_pin(pin_w),
        .o_sync_pin(sync_o), .o_sync_oe(sync_oe), .i_shutdown_input_n(trip_n),
        .o_trip_level(trip_lvl), .o_second_half(half),
        .o_phase0_high_out(outs[0]), .o_phase0_low_out(outs[1]),
        .o_phase1_high_out(outs[2]), .o_phase1_low_out(outs[3]),
        .o_phase2_high_out(outs[4]), .o_phase2_low_out(outs[5])
    );

    tip_gate_model i_gate (
        .i_mclk(i_mclk), .i_shutdown_input_n(trip_n), .i_drive(outs), .o_clash(clash)
    );

    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic timeout();
        fails++;
        $display("unexpected wait: expected done seen timeout");
        test_done();
    endtask

    task automatic tick();
        last_s = sync_o;
        last0  = outs[0];
        @(negedge i_mclk);
    endtask

    task automatic wait_rise();
        for (int i = 0; i < 400; i++) begin
            tick();
            if (sync_o === 1'b1 && last_s === 1'b0) return;
        end
        timeout();
    endtask

    task automatic wait_lvl(input logic v, input logic pick_trip, input int bound);
        for (int i = 0; i < bound; i++) begin
            tick();
            if ((pick_trip ? trip_lvl : half) === v) return;
        end
        timeout();
    endtask

    // one window spans n sync rises; chg loads a new phase 0 duty inside it
    task automatic measure(input int n, input logic chg);
        int k;
        wait_rise();
        t_per = 0;
        swc = 0;
        rises = 0;
        k = 0;
        for (int i = 0; i < NOUT; i++) hi[i] = 0;
        while (k < n) begin
            tick();
            t_per++;
            if (t_per > 400) timeout();
            if (sync_o === 1'b1 && last_s === 1'b0) k++;
            if (sync_o === 1'b1) swc++;
            if (outs[0] === 1'b1 && last0 === 1'b0) rises++;
            for (int i = 0; i < NOUT; i++) hi[i] += (outs[i] === 1'b1);
            if (chg && t_per == 3) begin
                @(posedge i_mclk);
                d0 <= 16'h0006;
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        check("reset drives", 6'h00, outs);
        check("reset half", 1'b0, half);
        check("reset trip level", 1'b1, trip_lvl);
        check("sync oe internal", 1'b1, sync_oe);
        @(posedge i_mclk);
        resetn <= 1'b1;
        run    <= 1'b1;
        measure(1, 1'b0);
        measure(1, 1'b0);
        t0 = t_per;
        check("sync width", 3, swc);
        @(posedge i_mclk);
        per <= 16'h000c;
        measure(1, 1'b0);
        measure(1, 1'b0);
        t1 = t_per;
        h0 = hi[0];
        l0 = hi[1];
        check("period growth", 8, t1 - t0);
        check("dead gap", 4, t1 - h0 - l0);
        check("duty p2 vs p0", 4, hi[4] - hi[0]);
        check("duty p0 vs p1", 4, hi[0] - hi[2]);
        measure(1, 1'b1);
        check("single keeps duty", h0, hi[0]);
        measure(1, 1'b0);
        check("single new duty", h0 + 4, hi[0]);
        @(posedge i_mclk);
        d0  <= 16'h0004;
        dbl <= 1'b1;
        measure(2, 1'b0);
        check("double pulses", t1, t_per);
        measure(2, 1'b1);
        check("double midpoint load", h0 + 2, hi[0]);
        @(posedge i_mclk);
        d0  <= 16'h0004;
        dbl <= 1'b0;
        oe  <= 6'h3e;
        measure(1, 1'b0);
        measure(1, 1'b0);
        check("disabled high", 0, hi[0]);
        check("enabled low", l0, hi[1]);
        @(posedge i_mclk);
        oe <= 6'h3f;
        xo <= 3'h1;
        measure(1, 1'b0);
        check("swap high", l0, hi[0]);
        check("swap low", h0, hi[1]);
        @(posedge i_mclk);
        xo  <= 3'h0;
        chh <= 1'b1;
        measure(1, 1'b0);
        check("chop high edges", 1, rises > 1);
        check("chop spares low", l0, hi[1]);
        @(posedge i_mclk);
        chh <= 1'b0;
        chl <= 1'b1;
        measure(1, 1'b0);
        check("chop spares high", h0, hi[0]);
        check("chop low cut", 1, hi[1] < l0);
        @(posedge i_mclk);
        chl <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            @(posedge i_mclk);
            rsy <= r[0];
            ext <= 1'b1;
            wait_lvl(1'b1, 1'b0, 60);
            check("sync oe external", 1'b0, sync_oe);
            @(posedge i_mclk);
            spin <= 1'b1;
            // held three clocks, longer than the two-clock minimum
            repeat (3) @(posedge i_mclk);
            spin <= 1'b0;
            wait_lvl(1'b0, 1'b0, 6);
            repeat (8) tick();
            check("restart holds up count", 1'b0, half);
            @(posedge i_mclk);
            ext <= 1'b0;
        end
        @(posedge i_mclk);
        trip_n <= 1'b0;
        #1;
        check("trip drives", 6'h3f, outs);
        wait_lvl(1'b0, 1'b1, 10);
        @(posedge i_mclk);
        trip_n <= 1'b1;
        wait_lvl(1'b1, 1'b1, 10);
        measure(1, 1'b0);
        check("shoot through", 0, clash);
        test_done();
    end
endmodule
`default_nettype wire
